/* File: logic/core_pkg.sv */
// Shared constants and types of the instruction execution core.
package core_pkg;
    // Data, instruction and address widths.
    localparam int DW          = 8;   // Operand width of the whole datapath.
    localparam int IW          = 16;  // Program memory word width.
    localparam int PAW         = 11;  // Program address width.
    localparam int DAW         = 8;   // Data memory address width.
    localparam int STACK_DEPTH = 4;   // Return address slots.
    // One instruction cycle in system clocks, and its phase markers.
    localparam int         CLKS_PER_ICYCLE = 4;
    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_FETCH = 2'h1;  // Program word is sampled here.
    localparam logic [1:0] PH_LAST  = 2'(CLKS_PER_ICYCLE - 1);
    // Instruction field positions.
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 11;
    localparam int DST_BIT = 8;    // High sends the result to data memory.
    localparam int SEL_MSB = 10;   // Bit index or sub-operation.
    localparam int SEL_LSB = 8;
    // Fixed addresses.
    localparam logic [DAW-1:0] PC_LOW_ADDR = 8'h02;
    localparam logic [PAW-1:0] RESET_PC    = 11'h000;
    localparam logic [PAW-1:0] INT_VECTOR  = 11'h004;
    localparam logic [PAW-1:0] TABLE_BASE  = 11'h700;
    // Sub-operations of the miscellaneous opcode.
    localparam logic [1:0] MISC_TABLE = 2'h0;
    localparam logic [1:0] MISC_HALT  = 2'h1;
    // Operation codes in bits 15 to 11 of the instruction word.
    typedef enum logic [4:0] {
        OP_NOP   = 5'h00, OP_MOVAM  = 5'h01, OP_MOVMA  = 5'h02, OP_MOVAX  = 5'h03,
        OP_ADD   = 5'h04, OP_ADC    = 5'h05, OP_SUB    = 5'h06, OP_SBC    = 5'h07,
        OP_ADDX  = 5'h08, OP_SUBX   = 5'h09, OP_AND    = 5'h0a, OP_OR     = 5'h0b,
        OP_XOR   = 5'h0c, OP_ANDX   = 5'h0d, OP_ORX    = 5'h0e, OP_XORX   = 5'h0f,
        OP_COMPL = 5'h10, OP_INC    = 5'h11, OP_DEC    = 5'h12, OP_ROTR   = 5'h13,
        OP_ROTL  = 5'h14, OP_ROTRC  = 5'h15, OP_ROTLC  = 5'h16, OP_SETB   = 5'h17,
        OP_CLRB  = 5'h18, OP_SZ     = 5'h19, OP_SZB    = 5'h1a, OP_SNZB   = 5'h1b,
        OP_BRANCH = 5'h1c, OP_CALL  = 5'h1d, OP_RETURN = 5'h1e, OP_MISC   = 5'h1f
    } opcode_t;
    // Sequencer states.
    typedef enum logic [1:0] {
        ST_EXEC  = 2'b00,
        ST_EXTRA = 2'b01,
        ST_HALT  = 2'b10
    } state_t;
endpackage

/* File: logic/core_dmem.sv */
// Data memory with a registered read port.
`timescale 1ns/10ps
module core_dmem #(
    parameter int AW = 8,
    parameter int DW = 8
)
(
    // Clock and reset.
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    // Access port.
    input  wire logic [AW-1:0] i_addr,
    input  wire logic          i_re,
    input  wire logic          i_we,
    input  wire logic [DW-1:0] i_wdata,
    output      logic [DW-1:0] o_rdata
);
    // Storage array; contents are undefined after reset, as in any RAM.
    logic [DW-1:0] mem [2**AW];

    // Writes land at the edge that sees the strobe.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_we)
        begin
            mem[i_addr] <= i_wdata;
        end
    end

    // Read data is held between reads so the core can use it for a whole cycle.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= '0;
        end
        else if (i_re)
        begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule

/* File: logic/core_alu.sv */
// Combinational arithmetic, logic, rotate and bit unit of the core.
`timescale 1ns/10ps
module core_alu (
    // Operation and operands.
    input  wire core_pkg::opcode_t          i_op,
    input  wire logic [core_pkg::DW-1:0]    i_accum,
    input  wire logic [core_pkg::DW-1:0]    i_mem,
    input  wire logic [core_pkg::DW-1:0]    i_imm,
    input  wire logic                       i_carry,
    input  wire logic [2:0]                 i_bit,
    // Result and flag updates.
    output      logic [core_pkg::DW-1:0]    o_result,
    output      logic                       o_carry,
    output      logic                       o_carry_we,
    output      logic                       o_zero_we
);
    import core_pkg::*;

    logic          use_imm;  // Second operand is the immediate byte.
    logic [DW-1:0] opnd;     // Selected second operand.
    logic [DW:0]   sum;      // Sum with carry out in the top bit.
    logic [DW:0]   diff;     // Difference with borrow in the top bit.
    logic [DW-1:0] mask;     // One-hot bit select.

    // Every operand is one byte wide.
    assign use_imm = i_op inside {OP_ADDX, OP_SUBX, OP_ANDX, OP_ORX, OP_XORX, OP_MOVAX};
    assign opnd    = use_imm ? i_imm : i_mem;
    assign sum     = {1'b0, i_accum} + {1'b0, opnd} + {{DW{1'b0}}, (i_op == OP_ADC) & i_carry};
    assign diff    = {1'b0, i_accum} - {1'b0, opnd} - {{DW{1'b0}}, (i_op == OP_SBC) & i_carry};
    assign mask    = DW'(1) << i_bit;
    // Flag write enables; rotates without carry leave both flags alone.
    assign o_carry_we = i_op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_ADDX, OP_SUBX,
                                     OP_ROTRC, OP_ROTLC};
    assign o_zero_we  = i_op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_ADDX, OP_SUBX,
                                     OP_AND, OP_OR, OP_XOR, OP_ANDX, OP_ORX, OP_XORX,
                                     OP_COMPL, OP_INC, OP_DEC};

    // Result and carry for each operation.
    always_comb
    begin
        o_result = i_mem;
        o_carry  = i_carry;
        case (i_op)
            OP_MOVMA:                    o_result = i_accum;
            OP_MOVAX:                    o_result = i_imm;
            OP_ADD, OP_ADC, OP_ADDX:
            begin
                o_result = sum[DW-1:0];
                o_carry  = sum[DW];   // Set when the sum passes 255.
            end
            OP_SUB, OP_SBC, OP_SUBX:
            begin
                o_result = diff[DW-1:0];
                o_carry  = diff[DW];  // Set on borrow below zero.
            end
            OP_AND, OP_ANDX:             o_result = i_accum & opnd;
            OP_OR, OP_ORX:               o_result = i_accum | opnd;
            OP_XOR, OP_XORX:             o_result = i_accum ^ opnd;
            OP_COMPL:                    o_result = ~i_mem;
            OP_INC:                      o_result = i_mem + DW'(1);
            OP_DEC:                      o_result = i_mem - DW'(1);
            OP_ROTR:                     o_result = {i_mem[0], i_mem[DW-1:1]};
            OP_ROTL:                     o_result = {i_mem[DW-2:0], i_mem[DW-1]};
            OP_ROTRC:
            begin
                o_result = {i_carry, i_mem[DW-1:1]};
                o_carry  = i_mem[0];  // Bit shifted out lands in carry.
            end
            OP_ROTLC:
            begin
                o_result = {i_mem[DW-2:0], i_carry};
                o_carry  = i_mem[DW-1];
            end
            OP_SETB:                     o_result = i_mem | mask;
            OP_CLRB:                     o_result = i_mem & ~mask;
            default:                     o_result = i_mem;
        endcase
    end
endmodule

/* File: logic/core_exec.sv */
// Instruction sequencer and execution core of the 8-bit controller.
// What this block does
// - Instruction cycle is four system clocks.
// - Ordinary instructions finish in one cycle.
// - Branch, call, returns, table read take two.
// - Writing program counter low byte jumps, adds cycle.
// - Taken skip adds a cycle; otherwise one.
// - Tests byte or bit, then skips or proceeds.
// - Call saves next address for return.
// - Branch loads target, saves no return.
// - Add carries past 255, subtract borrows.
// - Increment and decrement by exactly one.
// - Logical results of zero set zero flag.
// - AND, OR and XOR go through the accumulator.
// - Rotates move one bit; carry variants.
// - Bit set/clear changes only selected bit.
// - Moves between register, accumulator, immediate.
// - Table read fetches program memory data.
// - Halt instruction enters power-down.
// - Interrupt return sets enable; return keeps it.
`timescale 1ns/10ps
module core_exec #(
    parameter int STACK_DEPTH = core_pkg::STACK_DEPTH
)
(
    // Clock and reset.
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst_n,
    // Program memory port; the word must be valid two clocks after the address.
    output      logic [core_pkg::PAW-1:0]  o_pm_addr,
    input  wire logic [core_pkg::IW-1:0]   i_pm_data,
    // Interrupt request and wake-up.
    input  wire logic                      i_int_req,
    input  wire logic                      i_wake,
    // Core status.
    output      logic [core_pkg::DW-1:0]   o_accum,
    output      logic                      o_carry,
    output      logic                      o_zero,
    output      logic                      o_global_int_en,
    output      logic                      o_halted,
    output      logic                      o_instr_done
);
    import core_pkg::*;

    localparam int SPW = $clog2(STACK_DEPTH);

    // Sequencer registers.
    logic [1:0]     phase;                   // Clock within the instruction cycle.
    state_t         state;                   // Normal, extra cycle or halted.
    logic [PAW-1:0] pc;                      // Address of the current instruction.
    logic [IW-1:0]  ir;                      // Current instruction word.
    logic [DW-1:0]  tab_low;                 // Byte fetched by a table read.
    logic [SPW-1:0] sp;                      // Next free stack slot.
    logic [PAW-1:0] stack [STACK_DEPTH];     // Return addresses.

    // Decode and datapath wires.
    opcode_t        op;
    logic [DW-1:0]  imm, m_val, ram_rdata, ram_wdata, alu_res;
    logic [DAW-1:0] ram_addr;
    logic [2:0]     bit_sel;
    logic [PAW-1:0] pc_inc, stack_top, branch_target, tab_addr, next_pc;
    logic           exec_end, extra_end, fetch, ram_re, ram_we;
    logic           alu_c, carry_we, zero_we, sel_dst, wr_acc, wr_mem;
    logic           is_branch, is_call, is_return, is_int_return, is_table, is_halt;
    logic           skip_take, pc_low_write, needs_extra, irq_take, push, pop;

    // Phase markers.
    assign exec_end  = (state == ST_EXEC) && (phase == PH_LAST);
    assign extra_end = (state == ST_EXTRA) && (phase == PH_LAST);
    assign fetch     = (state == ST_EXEC) && (phase == PH_FETCH);

    // Field extraction.
    assign op            = opcode_t'(ir[OPC_MSB:OPC_LSB]);
    assign imm           = ir[DW-1:0];
    assign bit_sel       = ir[SEL_MSB:SEL_LSB];
    assign branch_target = ir[PAW-1:0];

    // Instruction classes.
    assign is_branch     = (op == OP_BRANCH);
    assign is_call       = (op == OP_CALL);
    assign is_return     = (op == OP_RETURN);
    assign is_int_return = is_return && ir[DST_BIT];
    assign is_table      = (op == OP_MISC) && (ir[SEL_LSB+1:SEL_LSB] == MISC_TABLE);
    assign is_halt       = (op == OP_MISC) && (ir[SEL_LSB+1:SEL_LSB] == MISC_HALT);

    // The program counter low byte reads as data at its own address.
    assign m_val = (ir[DAW-1:0] == PC_LOW_ADDR) ? pc[DW-1:0] : ram_rdata;

    // Destination select: logical results, except a complement sent to memory, involve the accumulator,
    // either as operand or as destination.
    assign sel_dst = op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
                                OP_COMPL, OP_INC, OP_DEC, OP_ROTR, OP_ROTL, OP_ROTRC,
                                OP_ROTLC};
    assign wr_acc  = (sel_dst && !ir[DST_BIT]) ||
                     (op inside {OP_ADDX, OP_SUBX, OP_ANDX, OP_ORX, OP_XORX, OP_MOVAM,
                                 OP_MOVAX});
    assign wr_mem  = (sel_dst && ir[DST_BIT]) || (op inside {OP_MOVMA, OP_SETB, OP_CLRB});

    // Conditional tests on a byte or on one of its bits.
    assign skip_take = ((op == OP_SZ) && ((m_val == '0) != ir[DST_BIT])) ||
                       ((op == OP_SZB) && !m_val[bit_sel]) ||
                       ((op == OP_SNZB) && m_val[bit_sel]);

    // A write aimed at the low program counter byte is a jump.
    assign pc_low_write = wr_mem && (ir[DAW-1:0] == PC_LOW_ADDR);

    // Which instructions need a second instruction cycle.
    assign needs_extra = is_branch || is_call || is_return || is_table ||
                         pc_low_write || skip_take;

    // Interrupts are taken only at the end of a single-cycle instruction,
    // which keeps the return address simple at the cost of a little latency.
    assign irq_take = i_int_req && o_global_int_en && !needs_extra && !is_halt;

    // Program counter selection.
    assign pc_inc    = pc + PAW'(1);
    assign stack_top = stack[sp - SPW'(1)];
    assign tab_addr  = {TABLE_BASE[PAW-1:DW], o_accum};
    assign next_pc   = (is_branch || is_call) ? branch_target :
                       is_return              ? stack_top :
                       pc_low_write           ? {pc_inc[PAW-1:DW], alu_res} :
                       skip_take              ? pc + PAW'(2) :
                       irq_take               ? INT_VECTOR :
                                                pc_inc;
    assign push      = exec_end && (is_call || irq_take);
    assign pop       = exec_end && is_return;

    // Data memory access: read while the word is fetched, write on the last clock.
    assign ram_addr  = fetch ? i_pm_data[DAW-1:0] : ir[DAW-1:0];
    assign ram_re    = fetch;
    assign ram_we    = (exec_end && wr_mem && !pc_low_write) ||
                       (extra_end && is_table);
    assign ram_wdata = (state == ST_EXTRA) ? tab_low : alu_res;

    // Data memory; a bit set or clear reads, modifies and writes the byte here.
    core_dmem #(
        .AW (DAW),
        .DW (DW)
    ) u_dmem (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_addr    (ram_addr),
        .i_re      (ram_re),
        .i_we      (ram_we),
        .i_wdata   (ram_wdata),
        .o_rdata   (ram_rdata)
    );

    // Arithmetic and logic unit.
    core_alu u_alu (
        .i_op       (op),
        .i_accum    (o_accum),
        .i_mem      (m_val),
        .i_imm      (imm),
        .i_carry    (o_carry),
        .i_bit      (bit_sel),
        .o_result   (alu_res),
        .o_carry    (alu_c),
        .o_carry_we (carry_we),
        .o_zero_we  (zero_we)
    );

    // Phase counter: four clocks make one instruction cycle.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            phase <= PH_FIRST;
        else
            phase <= (phase == PH_LAST) ? PH_FIRST : phase + 2'h1;
    end

    // Sequencer; state changes only on cycle boundaries.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            state    <= ST_EXEC;
            o_halted <= 1'b0;
        end
        else
        begin
            case (state)
                ST_EXEC:
                    if (exec_end && is_halt)
                    begin
                        state    <= ST_HALT;
                        o_halted <= 1'b1;
                    end
                    else if (exec_end && (needs_extra || irq_take))
                        state <= ST_EXTRA;
                ST_EXTRA:
                    if (phase == PH_LAST)
                        state <= ST_EXEC;
                ST_HALT:
                    if ((phase == PH_LAST) && (i_wake || i_int_req))
                    begin
                        state    <= ST_EXEC;
                        o_halted <= 1'b0;
                    end
                default:
                    state <= ST_EXEC;
            endcase
        end
    end

    // Program counter and fetch address.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            pc        <= RESET_PC;
            o_pm_addr <= RESET_PC;
        end
        else if (exec_end)
        begin
            pc        <= next_pc;
            o_pm_addr <= is_table ? tab_addr : next_pc;
        end
        else if (extra_end)
            o_pm_addr <= pc;
    end

    // Instruction and table word capture.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            ir      <= '0;
            tab_low <= '0;
        end
        else if (fetch)
            ir <= i_pm_data;
        else if ((state == ST_EXTRA) && (phase == PH_FETCH) && is_table)
            tab_low <= i_pm_data[DW-1:0];
    end

    // Accumulator and flags commit on the last clock of the first cycle.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_accum <= '0;
            o_carry <= 1'b0;
            o_zero  <= 1'b0;
        end
        else if (exec_end)
        begin
            if (wr_acc)
                o_accum <= alu_res;
            if (carry_we)
                o_carry <= alu_c;
            if (zero_we)
                o_zero <= (alu_res == '0);
        end
    end

    // Global interrupt enable: cleared on entry, set by interrupt return.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            o_global_int_en <= 1'b0;
        else if (exec_end && irq_take)
            o_global_int_en <= 1'b0;
        else if (exec_end && is_int_return)
            o_global_int_en <= 1'b1;
    end

    // Completion pulse one clock after the final cycle of each instruction.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            o_instr_done <= 1'b0;
        else
            o_instr_done <= (exec_end && !needs_extra && !irq_take) || extra_end;
    end

    // Stack pointer; it wraps when overfilled, so deep nesting loses the oldest entry.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            sp <= '0;
        else if (push)
            sp <= sp + SPW'(1);
        else if (pop)
            sp <= sp - SPW'(1);
    end

    // Return address storage; the saved point is the following instruction.
    always_ff @(posedge i_sys_clk)
    begin
        if (push)
            stack[sp] <= pc_inc;
    end

    // Checks on timing and results.
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    logic add_over;  // Helper: accumulator plus operand passes 255.
    assign add_over = ({1'b0, o_accum} + {1'b0, m_val}) > 9'h0ff;

    sequence s_extra_cycle;
        (state == ST_EXTRA) [*4] ##1 ((state == ST_EXEC) && o_instr_done);
    endsequence

    a_icycle_length: assert property (
        (phase == PH_LAST) |=> (phase == PH_FIRST) ##3 (phase == PH_LAST))
        else $error("instruction cycle is not four clocks");
    a_single_cycle: assert property (
        exec_end && !needs_extra && !irq_take && !is_halt |=> o_instr_done && (state == ST_EXEC))
        else $error("ordinary instruction did not finish in one cycle");
    a_two_cycle_ops: assert property (
        exec_end && (is_branch || is_call || is_return || is_table) |=> s_extra_cycle)
        else $error("control instruction did not take two cycles");
    a_pc_low_jump: assert property (
        exec_end && pc_low_write |=> (pc[DW-1:0] == $past(alu_res)) ##0 s_extra_cycle)
        else $error("program counter low write did not jump");
    a_skip_taken: assert property (
        exec_end && skip_take |=> (pc == $past(pc) + PAW'(2)) ##0 s_extra_cycle)
        else $error("taken skip wrong");
    a_call_saves: assert property (
        exec_end && is_call |=> (stack_top == $past(pc_inc)) && (sp == $past(sp) + SPW'(1)))
        else $error("call did not save return point");
    a_branch_target: assert property (
        exec_end && is_branch |=> (pc == $past(branch_target)) && $stable(sp))
        else $error("branch target or stack wrong");
    a_add_carry: assert property (
        exec_end && (op == OP_ADD) && add_over |=> o_carry)
        else $error("add carry missing");
    a_sub_borrow: assert property (
        exec_end && (op == OP_SUB) && (m_val > o_accum) |=> o_carry)
        else $error("subtract borrow missing");
    a_inc_accum: assert property (
        exec_end && (op == OP_INC) && !ir[DST_BIT] |=> o_accum == $past(m_val) + DW'(1))
        else $error("increment result wrong");
    a_and_zero: assert property (
        exec_end && (op == OP_AND) && !ir[DST_BIT] && ((o_accum & m_val) == '0)
        |=> o_zero && (o_accum == '0))
        else $error("zero flag not set");
    a_rot_carry: assert property (
        exec_end && (op == OP_ROTRC) && m_val[0] |=> o_carry)
        else $error("rotate carry wrong");
    a_bit_set: assert property (
        exec_end && (op == OP_SETB) && !pc_low_write
        |-> ram_we && (ram_wdata == (m_val | (DW'(1) << bit_sel))))
        else $error("bit set changed other bits");
    a_halt_enter: assert property (
        exec_end && is_halt |=> o_halted && (state == ST_HALT))
        else $error("halt did not power down");
    a_int_return: assert property (
        exec_end && is_return |=> is_int_return ? o_global_int_en : $stable(o_global_int_en))
        else $error("return changed interrupt enable wrongly");
endmodule

/* File: verif/instruction_execution_timing_test.sv */
// Self-checking bench: runs a small random program and checks results and cycle counts.
`timescale 1ns/10ps
module instruction_execution_timing_test;
    import core_pkg::*;
    logic                 i_sys_clk = 1'b0;  // System clock, 40 MHz.
    logic                 i_rst_n   = 1'b0;  // Synchronous reset, active low.
    logic                 i_int_req = 1'b0;  // Held low so the sequence stays predictable.
    logic                 i_wake    = 1'b0;  // Raised while halted, so a halt lasts one cycle.
    logic [IW-1:0]        i_pm_data = 16'h0000;
    logic [PAW-1:0]       o_pm_addr;
    logic [DW-1:0]        o_accum;
    logic                 o_carry, o_zero, o_global_int_en, o_halted, o_instr_done;
    logic [IW-1:0]        pm [0:2047];  // Program image; unused words trap with a marker.
    int                   e_acc[$], e_cyc[$], e_c[$], e_z[$], e_f[$];
    int                   fail_count = 0, checks = 0, gap = 0;
    logic [31:0]          seed = 32'h6606_1688;
    core_exec i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .o_pm_addr(o_pm_addr),
        .i_pm_data(i_pm_data), .i_int_req(i_int_req), .i_wake(i_wake), .o_accum(o_accum),
        .o_carry(o_carry), .o_zero(o_zero), .o_global_int_en(o_global_int_en),
        .o_halted(o_halted), .o_instr_done(o_instr_done));
    // Half-period toggle gives the 25 ns clock.
    always #12.5 i_sys_clk = ~i_sys_clk;
    // Program memory answers a little after each edge, well before phase 1 ends.
    always @(posedge i_sys_clk)
    begin
        #1;
        i_pm_data = pm[o_pm_addr];
        i_wake = o_halted;
    end
    // Xorshift keeps the random program repeatable.
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic push(input int acc, input int cyc, input int c, input int z, input int f = -1);
        e_acc.push_back(acc); e_cyc.push_back(cyc); e_c.push_back(c); e_z.push_back(z);
        e_f.push_back(f);  // Status as {interrupt enable, halted}; negative means unchecked.
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Each done pulse is compared with the next expected entry, clocks counted between pulses.
    always @(negedge i_sys_clk)
    begin
        gap++;
        if (i_rst_n && o_instr_done === 1'b1 && e_acc.size() > 0)
        begin
            chk_byte(o_accum, 8'(e_acc[0]), "accumulator");
            if (e_cyc[0] > 0) chk_byte(8'(gap), 8'(e_cyc[0]), "clocks");
            if (e_c[0] >= 0) chk_byte({7'h00, o_carry}, 8'(e_c[0]), "carry");
            if (e_z[0] >= 0) chk_byte({7'h00, o_zero}, 8'(e_z[0]), "zero");
            if (e_f[0] >= 0) chk_byte({6'h00, o_global_int_en, o_halted}, 8'(e_f[0]), "status");
            void'(e_acc.pop_front()); void'(e_cyc.pop_front());
            void'(e_c.pop_front()); void'(e_z.pop_front());
            void'(e_f.pop_front());
        end
        if (o_instr_done === 1'b1) gap = 0;
    end
    initial
    begin
        logic [7:0] a, b, c, d;
        logic [8:0] s, t;
        for (int i = 0; i < 2048; i++) pm[i] = {OP_MOVAX, 3'h0, 8'h5a};
        a = rnd(); b = rnd(); c = rnd(); d = rnd();
        s = {1'b0, a} + {1'b0, b};
        pm[0] = {OP_MOVAX, 3'h0, a};     push(a, 0, -1, -1);
        pm[1] = {OP_ADDX, 3'h0, b};      push(s[7:0], 4, s[8], -1);
        pm[2] = {OP_MOVMA, 3'h1, 8'h10}; push(s[7:0], 4, -1, -1);
        pm[3] = {OP_SUBX, 3'h0, c};      push(s[7:0] - c, 4, s[7:0] < c, -1);
        pm[4] = {OP_INC, 3'h0, 8'h10};   push(s[7:0] + 8'h01, 4, -1, -1);
        pm[5] = {OP_BRANCH, 11'h008};    push(s[7:0] + 8'h01, 8, -1, -1);
        pm[8] = {OP_CALL, 11'h020};      push(s[7:0] + 8'h01, 8, -1, -1);
        pm[32] = {OP_ANDX, 3'h0, 8'h00}; push(0, 4, -1, 1);
        pm[33] = {OP_RETURN, 11'h000};   push(0, 8, -1, -1);
        pm[9] = {OP_SZ, 3'h1, 8'h10};    push(0, (s[7:0] != 0) ? 8 : 4, -1, -1);
        pm[10] = {OP_MOVAX, 3'h0, 8'hee};
        if (s[7:0] == 0) push(8'hee, 4, -1, -1);
        pm[11] = {OP_MOVAX, 3'h0, d};    push(d, 4, -1, -1);
        t = {1'b0, d} + {1'b0, s[7:0]};
        pm[12] = {OP_ADD, 3'h0, 8'h10};   push(t[7:0], 4, t[8], t[7:0] == 0);
        pm[13] = {OP_SUB, 3'h0, 8'h10};   push(d, 4, s[7:0] > t[7:0], -1);
        pm[14] = {OP_COMPL, 3'h0, 8'h10}; push(~s[7:0], 4, -1, s[7:0] == 8'hff);
        pm[15] = {OP_AND, 3'h0, 8'h10};   push(0, 4, -1, 1);
        pm[16] = {OP_ROTRC, 3'h0, 8'h10}; push({s[7:0] > t[7:0], s[7:1]}, 4, s[0], -1);
        pm[17] = {OP_SETB, 3'h3, 8'h10};  push({s[7:0] > t[7:0], s[7:1]}, 4, -1, -1);
        pm[18] = {OP_MOVAM, 3'h0, 8'h10}; push(s[7:0] | 8'h08, 4, -1, -1);
        pm[{TABLE_BASE[PAW-1:DW], s[7:0] | 8'h08}] = {8'h00, c};
        pm[19] = {OP_MISC, 3'h0, 8'h11};  push(s[7:0] | 8'h08, 8, -1, -1);
        pm[20] = {OP_MOVAM, 3'h0, 8'h11}; push(c, 4, -1, -1);
        pm[21] = {OP_CALL, 11'h040};      push(c, 8, -1, -1);
        pm[64] = {OP_RETURN, 11'h100};    push(c, 8, -1, -1, 2);
        pm[22] = {OP_MISC, 3'h1, 8'h00};  push(c, 4, -1, -1, 3);
        pm[23] = {OP_SETB, 3'h5, 8'h02};  push(c, 12, -1, -1, 2);
        pm[55] = {OP_BRANCH, 11'h037};    push(c, 8, -1, -1, 2);
        repeat (3) @(posedge i_sys_clk);
        #1 i_rst_n = 1'b1;
        for (int k = 0; k < 300 && e_acc.size() > 0; k++) @(posedge i_sys_clk);
        if (e_acc.size() > 0) fail_count++;
        conclude();
    end
    // Watchdog: the program needs under 200 clocks.
    initial
    begin
        #(25 * 1000);
        fail_count++;
        conclude();
    end
endmodule
